// ===== tb/rtc_locked_indirect_access_tb.sv
// self-checking bench for the locked indirect timekeeper port
// assumes the core model drives the bus and the bench drives the rest
module rtc_locked_indirect_access_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [7:0] ADR = rtc_pkg::SFR_ADR;
   localparam logic [7:0] DAT = rtc_pkg::SFR_DAT;
   localparam logic [7:0] KEY = rtc_pkg::SFR_KEY;

   logic i_clk_sys = 1'b0;
   logic i_arst_n = 1'b0;
   logic i_por_n = 1'b0;
   logic i_rtc_tick = 1'b0;
   logic i_osc_missing = 1'b0;
   rtc_pkg::sfr_req_t sfr;
   logic [7:0] o_sfr_rdata;
   logic o_alarm_evt;
   logic o_osc_missing_evt;
   logic o_xtal_short;
   int fail_count = 0;
   int tests_run = 0;
   int alarm_seen = 0;
   int osc_seen = 0;
   integer seed = 32'hc8bc;
   logic [31:0] alarm;
   logic [31:0] cap;
   logic [7:0] v;
   logic [7:0] bad;
   int ones;

   always #5 i_clk_sys = ~i_clk_sys;

   // -----------------------------------------------------------------
   // design and core model
   // -----------------------------------------------------------------
   rtc_locked_indirect_access rtc_locked_indirect_access_i (
      .i_clk_sys(i_clk_sys),
      .i_arst_n(i_arst_n),
      .i_por_n(i_por_n),
      .i_sfr(sfr),
      .o_sfr_rdata(o_sfr_rdata),
      .i_rtc_tick(i_rtc_tick),
      .i_osc_missing(i_osc_missing),
      .o_alarm_evt(o_alarm_evt),
      .o_osc_missing_evt(o_osc_missing_evt),
      .o_xtal_short(o_xtal_short)
   );

   sfr_master_model sfr_master_model_i (
      .i_clk_sys(i_clk_sys),
      .i_rdata(o_sfr_rdata),
      .o_sfr(sfr)
   );

   // event pulses are one cycle wide, so count them on every edge
   always @(posedge i_clk_sys)
   begin
      if (o_alarm_evt === 1'b1) alarm_seen++;
      if (o_osc_missing_evt === 1'b1) osc_seen++;
   end

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // polling keeps us clear of in-flight transfers without relying on spacing
   task automatic wait_idle;
      logic [7:0] s;
      int n;
      s = 8'hFF;
      n = 0;
      while (s[7] !== 1'b0 && n < 20)
      begin
         sfr_master_model_i.rd(ADR, s);
         n++;
      end
      if (s[7] !== 1'b0)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, s, 8'h00);
         stop_test();
      end
   endtask

   task automatic key_check(input logic [7:0] exp);
      sfr_master_model_i.rd(KEY, v);
      check(v, exp);
   endtask

   task automatic unlock;
      sfr_master_model_i.wr(KEY, rtc_pkg::KEY_FIRST);
      key_check(rtc_pkg::ST_FIRST);
      key_check(rtc_pkg::ST_FIRST);
      sfr_master_model_i.wr(KEY, rtc_pkg::KEY_SECOND);
      key_check(rtc_pkg::ST_UNLOCKED);
   endtask

   // one data write per byte, lowest byte first, polled or spaced between
   // spacing alone is only safe with short strobe set in a
   task automatic put_word(input logic [7:0] a, input logic [31:0] w, input bit spaced);
      sfr_master_model_i.wr(ADR, a);
      for (int i = 0; i < 4; i++)
      begin
         sfr_master_model_i.wr(DAT, w[8*i +: 8]);
         if (spaced)
            repeat (5) @(posedge i_clk_sys);
         else
            wait_idle();
      end
   endtask

   task automatic tick;
      @(posedge i_clk_sys);
      i_rtc_tick <= 1'b1;
      @(posedge i_clk_sys);
      i_rtc_tick <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
   endtask

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial
   begin
      alarm = $random(seed);
      cap = alarm - 32'h2;
      repeat (6) @(posedge i_clk_sys);
      i_por_n <= 1'b1;
      i_arst_n <= 1'b1;
      key_check(rtc_pkg::ST_LOCKED);
      check({7'h00, o_xtal_short}, 8'h00);
      $display("reset test done");

      unlock();
      sfr_master_model_i.rd(ADR, v);
      check(v, 8'h10);
      $display("unlock test done");

      sfr_master_model_i.burst(8'h95, 10, ones);
      check(8'(ones), 8'h06);
      wait_idle();
      sfr_master_model_i.burst(8'h85, 10, ones);
      check(8'(ones), 8'h07);
      wait_idle();
      $display("strobe length test done");

      put_word(8'h18, alarm, 1'b0);
      sfr_master_model_i.rd(ADR, v);
      check(v, 8'h1C);
      sfr_master_model_i.wr(ADR, 8'hD8);
      wait_idle();
      for (int i = 0; i < 4; i++)
      begin
         sfr_master_model_i.rd(DAT, v);
         check(v, alarm[8*i +: 8]);
         wait_idle();
      end
      sfr_master_model_i.wr(ADR, 8'h1B);
      sfr_master_model_i.rd(DAT, v);
      check(v, rtc_pkg::IREG_RST);
      $display("alarm bytes test done");

      put_word(8'h10, cap, 1'b1);
      sfr_master_model_i.wr(ADR, 8'h14);
      sfr_master_model_i.wr(DAT, 8'h8A);
      wait_idle();
      sfr_master_model_i.rd(ADR, v);
      check(v, 8'h14);
      tick();
      check(8'(alarm_seen), 8'h00);
      tick();
      check(8'(alarm_seen), 8'h01);
      @(posedge i_clk_sys);
      i_osc_missing <= 1'b1;
      repeat (5) @(posedge i_clk_sys);
      i_osc_missing <= 1'b0;
      check(8'(osc_seen), 8'h01);
      $display("event test done");

      // single short read by spacing alone: the read lands on the first idle cycle
      sfr_master_model_i.wr(ADR, 8'h98);
      repeat (5) @(posedge i_clk_sys);
      sfr_master_model_i.rd(DAT, v);
      check(v, alarm[7:0]);
      $display("spaced read test done");

      sfr_master_model_i.wr(ADR, 8'h17);
      sfr_master_model_i.wr(DAT, 8'h80);
      wait_idle();
      check({7'h00, o_xtal_short}, 8'h01);
      $display("pin short test done");

      sfr_master_model_i.wr(ADR, 8'h47);
      sfr_master_model_i.wr(KEY, 8'($random(seed)));
      key_check(rtc_pkg::ST_LOCKED);
      bad = 8'($random(seed));
      if (bad === rtc_pkg::KEY_SECOND) bad = ~bad;
      sfr_master_model_i.wr(KEY, rtc_pkg::KEY_FIRST);
      sfr_master_model_i.wr(KEY, bad);
      key_check(rtc_pkg::ST_DISABLED);
      sfr_master_model_i.wr(KEY, rtc_pkg::KEY_FIRST);
      key_check(rtc_pkg::ST_DISABLED);
      $display("lock violation test done");

      // device reset only: address field, autoread and data must survive it, short strobe returns to on
      @(posedge i_clk_sys);
      i_arst_n <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_arst_n <= 1'b1;
      key_check(rtc_pkg::ST_LOCKED);
      unlock();
      sfr_master_model_i.rd(ADR, v);
      check(v, 8'h57);
      check({7'h00, o_xtal_short}, 8'h00);
      $display("retention test done");

      // relock, then touch the data register while locked
      sfr_master_model_i.wr(KEY, 8'($random(seed)));
      sfr_master_model_i.rd(DAT, v);
      check(v, 8'h00);
      key_check(rtc_pkg::ST_DISABLED);
      $display("locked access test done");
      stop_test();
   end
endmodule

// ===== tb/sfr_master_model.sv
// processor core model: drives one-cycle strobes on the register bus
// assumes the bench calls its tasks from one process only
module sfr_master_model (
   // clock and read answer
   input wire logic i_clk_sys,
   input wire logic [7:0] i_rdata,
   // bus request
   output rtc_pkg::sfr_req_t o_sfr
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus: unmapped address, so nothing is taken between accesses
   initial o_sfr = '0;

   // -----------------------------------------------------------------
   // bus cycles
   // -----------------------------------------------------------------
   // write: strobe held to the taking edge, data inverted on release
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      o_sfr.wr <= 1'b1;
      o_sfr.addr <= a;
      o_sfr.wdata <= d;
      @(posedge i_clk_sys);
      o_sfr.wr <= 1'b0;
      o_sfr.addr <= 8'h00;
      o_sfr.wdata <= ~d;
   endtask

   // read: answer is registered, so it is taken just after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk_sys);
      o_sfr.rd <= 1'b1;
      o_sfr.addr <= a;
      @(posedge i_clk_sys);
      o_sfr.rd <= 1'b0;
      o_sfr.addr <= 8'h00;
      #1 d = i_rdata;
   endtask

   // address write, then n back-to-back address reads counting busy ones
   task automatic burst(input logic [7:0] d, input int n, output int ones);
      ones = 0;
      @(posedge i_clk_sys);
      o_sfr.wr <= 1'b1;
      o_sfr.addr <= rtc_pkg::SFR_ADR;
      o_sfr.wdata <= d;
      for (int k = 0; k <= n; k++)
      begin
         @(posedge i_clk_sys);
         o_sfr.wr <= 1'b0;
         o_sfr.wdata <= ~d;
         o_sfr.rd <= (k < n);
         if (k == n) o_sfr.addr <= 8'h00;
         if (k > 0) #1 ones += int'(i_rdata[7]);
      end
   endtask
endmodule

// ===== verilog/rtc_locked_indirect_access.sv
// lock-protected indirect access port to a 32-bit timekeeping counter
// assumes bus strobes are one cycle wide and synchronous to i_clk_sys
module rtc_locked_indirect_access (
   // clock and resets
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_por_n,
   // processor register bus
   input wire rtc_pkg::sfr_req_t i_sfr,
   output logic [7:0] o_sfr_rdata,
   // timebase and oscillator status
   input wire logic i_rtc_tick,
   input wire logic i_osc_missing,
   // events and pin control
   output logic o_alarm_evt,
   output logic o_osc_missing_evt,
   output logic o_xtal_short
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      rtc_pkg::lock_state_t lock;
      logic short_en;
      logic busy;
      logic [2:0] cnt;
      logic op_wr;
      logic [3:0] op_addr;
      logic [7:0] wbuf;
      logic [11:0][7:0] ireg;
      logic [31:0] counter;
      logic [7:0] rdata;
      logic alm_evt;
      logic osc_evt;
      logic osc_prev;
   } core_state_t;

   core_state_t s_r;
   core_state_t s_nxt;
   rtc_pkg::retained_t ret_r;
   rtc_pkg::retained_t ret_nxt;
   logic key_wr;
   logic key_rd;
   logic adr_wr;
   logic adr_rd;
   logic dat_wr;
   logic dat_rd;
   logic unl;
   logic done;
   logic start;
   logic start_short;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic ia_mapped(input logic [3:0] a);
      ia_mapped = (a <= rtc_pkg::IA_ALARM3);
   endfunction

   // capture and alarm bytes are the only ones that step the address
   function automatic logic ia_multi(input logic [3:0] a);
      ia_multi = (a <= rtc_pkg::IA_CAPTURE3) ||
                 ((a >= rtc_pkg::IA_ALARM0) && (a <= rtc_pkg::IA_ALARM3));
   endfunction

   function automatic logic [7:0] lock_code(input rtc_pkg::lock_state_t l);
      unique case (l)
         rtc_pkg::LK_LOCKED: lock_code = rtc_pkg::ST_LOCKED;
         rtc_pkg::LK_FIRST: lock_code = rtc_pkg::ST_FIRST;
         rtc_pkg::LK_UNLOCKED: lock_code = rtc_pkg::ST_UNLOCKED;
         rtc_pkg::LK_DISABLED: lock_code = rtc_pkg::ST_DISABLED;
         default: lock_code = rtc_pkg::ST_DISABLED;
      endcase
   endfunction

   // -----------------------------------------------------------------
   // bus decode: only three addresses exist on the processor bus
   // -----------------------------------------------------------------
   assign key_wr = i_sfr.wr && (i_sfr.addr == rtc_pkg::SFR_KEY); // RQ1
   assign key_rd = i_sfr.rd && (i_sfr.addr == rtc_pkg::SFR_KEY);
   assign adr_wr = i_sfr.wr && (i_sfr.addr == rtc_pkg::SFR_ADR); // RQ1
   assign adr_rd = i_sfr.rd && (i_sfr.addr == rtc_pkg::SFR_ADR);
   assign dat_wr = i_sfr.wr && (i_sfr.addr == rtc_pkg::SFR_DAT); // RQ1
   assign dat_rd = i_sfr.rd && (i_sfr.addr == rtc_pkg::SFR_DAT);
   assign unl = (s_r.lock == rtc_pkg::LK_UNLOCKED);
   assign done = s_r.busy && (s_r.cnt == 3'h0);

   // a new transfer is refused while one is running
   assign start = unl && !s_r.busy &&
                  ((adr_wr && i_sfr.wdata[rtc_pkg::ADR_BUSY_BIT]) || // RQ10
                   dat_wr || // RQ9
                   (dat_rd && ret_r.autoread_enable)); // RQ16
   assign start_short = adr_wr ? i_sfr.wdata[rtc_pkg::ADR_SHORT_BIT] : s_r.short_en;

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      ret_nxt = ret_r;
      s_nxt.alm_evt = 1'b0;
      s_nxt.osc_evt = i_osc_missing && !s_r.osc_prev; // RQ23
      s_nxt.osc_prev = i_osc_missing;

      // lock sequencer; a key read changes nothing here
      if (key_wr)
      begin
         unique case (s_r.lock)
            rtc_pkg::LK_LOCKED: s_nxt.lock = (i_sfr.wdata == rtc_pkg::KEY_FIRST) ?
               rtc_pkg::LK_FIRST : rtc_pkg::LK_DISABLED; // RQ4
            rtc_pkg::LK_FIRST: s_nxt.lock = (i_sfr.wdata == rtc_pkg::KEY_SECOND) ?
               rtc_pkg::LK_UNLOCKED : rtc_pkg::LK_DISABLED; // RQ5
            rtc_pkg::LK_UNLOCKED: s_nxt.lock = rtc_pkg::LK_LOCKED; // RQ6
            rtc_pkg::LK_DISABLED: s_nxt.lock = rtc_pkg::LK_DISABLED; // RQ24
            default: s_nxt.lock = rtc_pkg::LK_DISABLED;
         endcase
      end
      // touching address or data while not unlocked is a violation
      if ((adr_wr || adr_rd || dat_wr || dat_rd) && !unl)
      begin
         s_nxt.lock = rtc_pkg::LK_DISABLED; // RQ5
      end

      // strobe counter and completion of a transfer
      if (s_r.busy)
      begin
         if (s_r.cnt == 3'h0)
         begin
            s_nxt.busy = 1'b0; // RQ26
            if (s_r.op_wr && ia_mapped(s_r.op_addr))
            begin
               s_nxt.ireg[s_r.op_addr] = s_r.wbuf; // RQ2 RQ3
            end
            if (!s_r.op_wr)
            begin
               ret_nxt.data = ia_mapped(s_r.op_addr) ? s_r.ireg[s_r.op_addr] : 8'h00; // RQ11
            end
            if (ia_multi(s_r.op_addr))
            begin
               ret_nxt.addr = s_r.op_addr + 4'h1; // RQ19
            end
         end
         else
         begin
            s_nxt.cnt = s_r.cnt - 3'h1;
         end
      end

      // address register write; a fresh address wins over the increment
      if (unl && adr_wr)
      begin
         ret_nxt.addr = i_sfr.wdata[3:0]; // RQ25
         ret_nxt.autoread_enable = i_sfr.wdata[rtc_pkg::ADR_AUTOREAD_ENABLE_BIT]; // RQ18
         s_nxt.short_en = i_sfr.wdata[rtc_pkg::ADR_SHORT_BIT]; // RQ15
      end
      if (unl && dat_wr && !s_r.busy)
      begin
         ret_nxt.data = i_sfr.wdata; // RQ9
      end

      // launch: the target is latched so a later address write cannot move it
      if (start)
      begin
         s_nxt.busy = 1'b1; // RQ26
         s_nxt.cnt = start_short ? rtc_pkg::STROBE_SHORT_CYC - 3'h1 :
                                   rtc_pkg::STROBE_LONG_CYC - 3'h1; // RQ14
         s_nxt.op_wr = dat_wr;
         s_nxt.op_addr = adr_wr ? i_sfr.wdata[3:0] : ret_r.addr; // RQ8
         s_nxt.wbuf = i_sfr.wdata;
      end

      // counter set and capture requests act once, then clear themselves
      if (s_r.ireg[rtc_pkg::IA_CONTROL][rtc_pkg::CTL_SET_BIT])
      begin
         s_nxt.counter = {s_r.ireg[3], s_r.ireg[2], s_r.ireg[1], s_r.ireg[0]};
         s_nxt.ireg[rtc_pkg::IA_CONTROL][rtc_pkg::CTL_SET_BIT] = 1'b0;
      end
      else if (s_r.ireg[rtc_pkg::IA_CONTROL][rtc_pkg::CTL_RUN_BIT] && i_rtc_tick)
      begin
         s_nxt.counter = s_r.counter + 32'h0000_0001;
         s_nxt.alm_evt = s_r.ireg[rtc_pkg::IA_CONTROL][rtc_pkg::CTL_ALARM_EN_BIT] &&
            ((s_r.counter + 32'h0000_0001) ==
             {s_r.ireg[11], s_r.ireg[10], s_r.ireg[9], s_r.ireg[8]}); // RQ23
      end
      if (s_r.ireg[rtc_pkg::IA_CONTROL][rtc_pkg::CTL_CAPTURE_BIT])
      begin
         {s_nxt.ireg[3], s_nxt.ireg[2], s_nxt.ireg[1], s_nxt.ireg[0]} = s_r.counter;
         s_nxt.ireg[rtc_pkg::IA_CONTROL][rtc_pkg::CTL_CAPTURE_BIT] = 1'b0;
      end

      // read answer, registered; address and data read zero unless unlocked
      if (key_rd)
      begin
         s_nxt.rdata = lock_code(s_r.lock); // RQ7 RQ24
      end
      else if (adr_rd)
      begin
         s_nxt.rdata = unl ? {s_r.busy, ret_r.autoread_enable, 1'b0, s_r.short_en, ret_r.addr} :
                             8'h00; // RQ26
      end
      else if (dat_rd)
      begin
         s_nxt.rdata = unl ? ret_r.data : 8'h00; // RQ11
      end
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         s_r <= '0;
         s_r.lock <= rtc_pkg::LK_LOCKED;
         s_r.short_en <= rtc_pkg::SHORT_RST; // RQ15
         s_r.ireg <= {12{rtc_pkg::IREG_RST}};
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // address and data sit on the power-on reset only
   rtc_retained_regs rtc_retained_regs_i (
      .i_clk_sys(i_clk_sys),
      .i_por_n(i_por_n),
      .i_ret_nxt(ret_nxt),
      .o_ret_r(ret_r)
   );

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign o_sfr_rdata = s_r.rdata;
   assign o_alarm_evt = s_r.alm_evt;
   assign o_osc_missing_evt = s_r.osc_evt;
   // bit 7 only; the other pin bits are stored but steer nothing
   assign o_xtal_short = s_r.ireg[rtc_pkg::IA_PIN_CFG][rtc_pkg::PIN_SHORT_BIT]; // RQ22

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_arst_n);

   sequence seq_start_long;
      start && !start_short;
   endsequence

   sequence seq_start_short;
      start && start_short;
   endsequence

   sequence seq_busy_long;
      s_r.busy [*7] ##1 !s_r.busy;
   endsequence

   sequence seq_busy_short;
      s_r.busy [*6] ##1 !s_r.busy;
   endsequence

   first_key_a: assert property ( // RQ4
      (key_wr && s_r.lock == rtc_pkg::LK_LOCKED && i_sfr.wdata == rtc_pkg::KEY_FIRST)
      |=> s_r.lock == rtc_pkg::LK_FIRST)
      else $error("first key not accepted");

   wrong_key_a: assert property ( // RQ5
      (key_wr && s_r.lock == rtc_pkg::LK_FIRST && i_sfr.wdata != rtc_pkg::KEY_SECOND)
      |=> s_r.lock == rtc_pkg::LK_DISABLED)
      else $error("wrong second key did not disable");

   locked_access_a: assert property ( // RQ5
      ((adr_wr || dat_wr || dat_rd) && !unl) |=> s_r.lock == rtc_pkg::LK_DISABLED)
      else $error("access while locked did not disable");

   disabled_stays_a: assert property ( // RQ24
      s_r.lock == rtc_pkg::LK_DISABLED |=> s_r.lock == rtc_pkg::LK_DISABLED)
      else $error("left disabled state without reset");

   relock_key_a: assert property ( // RQ6
      (key_wr && unl) |=> s_r.lock == rtc_pkg::LK_LOCKED)
      else $error("key write while unlocked did not lock");

   key_read_a: assert property ( // RQ7
      (key_rd && !i_sfr.wr) |=> (s_r.lock == $past(s_r.lock) &&
                                 o_sfr_rdata == lock_code($past(s_r.lock))))
      else $error("key read disturbed state or gave wrong status");

   long_strobe_a: assert property (seq_start_long |=> seq_busy_long) // RQ14
      else $error("long strobe is not seven cycles");

   short_strobe_a: assert property (seq_start_short |=> seq_busy_short) // RQ14
      else $error("short strobe is not six cycles");

   addr_step_a: assert property ( // RQ19
      (done && ia_multi(s_r.op_addr) && !adr_wr)
      |=> ret_r.addr == $past(s_r.op_addr) + 4'h1)
      else $error("address did not step after multi-byte access");

   read_copy_a: assert property ( // RQ11
      (done && !s_r.op_wr && ia_mapped(s_r.op_addr))
      |=> ret_r.data == $past(s_r.ireg[s_r.op_addr]))
      else $error("indirect read did not land in data");

   // a refused data write must leave the data register alone
   busy_refuse_a: assert property ( // RQ11
      (dat_wr && s_r.busy && !done) |=> $stable(ret_r.data))
      else $error("data write while busy changed the data register");

   data_load_a: assert property ( // RQ9
      (dat_wr && unl && !s_r.busy) |=> ret_r.data == $past(i_sfr.wdata))
      else $error("accepted data write did not load the data register");

   write_land_a: assert property ( // RQ2 RQ3
      (done && s_r.op_wr && ia_mapped(s_r.op_addr))
      |=> s_r.ireg[$past(s_r.op_addr)] == $past(s_r.wbuf))
      else $error("indirect write did not reach its target");

   addr_write_a: assert property ( // RQ25 RQ18 RQ15
      (adr_wr && unl)
      |=> (ret_r.addr == $past(i_sfr.wdata[3:0]) &&
           ret_r.autoread_enable == $past(i_sfr.wdata[rtc_pkg::ADR_AUTOREAD_ENABLE_BIT]) &&
           s_r.short_en == $past(i_sfr.wdata[rtc_pkg::ADR_SHORT_BIT])))
      else $error("address register write did not take its fields");

   // refused reads must not leak the address or data contents
   locked_read_a: assert property ( // RQ5
      ((adr_rd || dat_rd) && !unl) |=> o_sfr_rdata == 8'h00)
      else $error("read while not unlocked returned nonzero data");

   osc_event_a: assert property ( // RQ23
      (i_osc_missing && !s_r.osc_prev) |=> o_osc_missing_evt)
      else $error("missing oscillator rise gave no event");

   alarm_match_a: assert property ( // RQ23
      o_alarm_evt |-> s_r.counter == $past({s_r.ireg[11], s_r.ireg[10], s_r.ireg[9], s_r.ireg[8]}))
      else $error("alarm event without a counter match");

endmodule

// ===== verilog/rtc_pkg.sv
// constants, carriers and state codes of the locked indirect timekeeper port
// assumes one system clock and a processor register bus with one-cycle strobes
//
// Summary of operation
// RQ1: internal timekeeper registers are reached only through key, address and data
// RQ2: internal 0x00-0x03 capture bytes, 0x04 control, 0x05-0x06 oscillator, 0x07 pins
// RQ3: internal 0x08-0x0B are four alarm bytes, writable and readable back
// RQ4: writing 0xA5 then 0xF1 to the key unlocks, with no time limit
// RQ5: wrong key, wrong order or access while locked disables until reset
// RQ6: unlocked allows any number of accesses; any key write locks again
// RQ7: key read returns lock status and never disturbs a sequence in progress
// RQ8: the address field selects the target of following indirect accesses
// RQ9: a data register write starts an indirect write of that byte
// RQ10: writing one to address bit 7 starts an indirect read into data
// RQ11: read data stays in the data register until the next operation
// RQ12: software polls busy until zero unless it keeps the recommended spacing
// RQ13: address and data registers keep their contents through a device reset; the code resets the short strobe bit (bit 4) to on
// RQ14: an indirect access takes 7 cycles, or 6 with short strobe
// RQ15: short strobe is on after reset and set or cleared by address bit 4
// RQ16: with autoread each data register read starts the next indirect read
// RQ17: with autoread software sets busy once and spaces or polls each read
// RQ18: address bit 6 set enables autoread, cleared disables it
// RQ19: address field increments after every capture or alarm access; an address write in the completing cycle replaces the increment
// RQ20: single short read: write address with busy, three idle slots, read
// RQ21: multi-byte short write: set address, then data bytes with one idle slot
// RQ22: pin configuration holds a control that shorts the two crystal pins
// RQ23: alarm match and missing oscillator events are provided to the system
// RQ24: key status 0 locked, 1 first key, 2 unlocked, 3 disabled; then no effect
// RQ25: internal address occupies address register bits 3 to 0
// RQ26: busy reads one during a transfer and clears after the strobe length
package rtc_pkg;

   // -----------------------------------------------------------------
   // processor register bus addresses and key codes
   // -----------------------------------------------------------------
   localparam logic [7:0] SFR_ADR = 8'hAC;
   localparam logic [7:0] SFR_DAT = 8'hAD;
   localparam logic [7:0] SFR_KEY = 8'hAE;
   localparam logic [7:0] KEY_FIRST = 8'hA5;
   localparam logic [7:0] KEY_SECOND = 8'hF1;

   // -----------------------------------------------------------------
   // status codes, address register fields, strobe lengths
   // -----------------------------------------------------------------
   localparam logic [7:0] ST_LOCKED = 8'h00;
   localparam logic [7:0] ST_FIRST = 8'h01;
   localparam logic [7:0] ST_UNLOCKED = 8'h02;
   localparam logic [7:0] ST_DISABLED = 8'h03;
   localparam int ADR_BUSY_BIT = 7;
   localparam int ADR_AUTOREAD_ENABLE_BIT = 6;
   localparam int ADR_SHORT_BIT = 4;
   localparam logic SHORT_RST = 1'b1;
   localparam logic [2:0] STROBE_LONG_CYC = 3'h7;
   localparam logic [2:0] STROBE_SHORT_CYC = 3'h6;

   // -----------------------------------------------------------------
   // internal register map and control fields
   // -----------------------------------------------------------------
   localparam logic [3:0] IA_CAPTURE0 = 4'h0;
   localparam logic [3:0] IA_CAPTURE3 = 4'h3;
   localparam logic [3:0] IA_CONTROL = 4'h4;
   localparam logic [3:0] IA_OSC_CTL = 4'h5;
   localparam logic [3:0] IA_OSC_CFG = 4'h6;
   localparam logic [3:0] IA_PIN_CFG = 4'h7;
   localparam logic [3:0] IA_ALARM0 = 4'h8;
   localparam logic [3:0] IA_ALARM3 = 4'hB;
   localparam int CTL_CAPTURE_BIT = 0;
   localparam int CTL_SET_BIT = 1;
   localparam int CTL_ALARM_EN_BIT = 3;
   localparam int CTL_RUN_BIT = 7;
   localparam int PIN_SHORT_BIT = 7;
   localparam logic [7:0] IREG_RST = 8'h00;

   // -----------------------------------------------------------------
   // carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

   typedef struct packed {
      logic autoread_enable;
      logic [3:0] addr;
      logic [7:0] data;
   } retained_t;

   typedef enum logic [3:0] {
      LK_LOCKED = 4'b0001,
      LK_FIRST = 4'b0010,
      LK_UNLOCKED = 4'b0100,
      LK_DISABLED = 4'b1000
   } lock_state_t;

endpackage

// ===== verilog/rtc_retained_regs.sv
// address and data interface registers that survive a device reset
// assumes i_por_n is the power-on reset, asserted only when supply comes up
module rtc_retained_regs (
   // clock and power-on reset
   input wire logic i_clk_sys,
   input wire logic i_por_n,
   // next value from the access engine
   input wire rtc_pkg::retained_t i_ret_nxt,
   // held value
   output rtc_pkg::retained_t o_ret_r
);

   typedef struct packed {
      rtc_pkg::retained_t ret;
   } ret_state_t;

   ret_state_t s_r;
   ret_state_t s_nxt;

   // next state simply follows the engine
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.ret = i_ret_nxt;
   end

   // only power-on clears these, a device reset leaves them alone
   always_ff @(posedge i_clk_sys or negedge i_por_n)
   begin
      if (!i_por_n)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt; // RQ13
      end
   end

   assign o_ret_r = s_r.ret;

endmodule
